// ---- logic/ddsc_ctl.sv ----
// Purpose: External controller end: forwards software writes and reads to the link
// Assumes: Software port strobes are one cycle and never both at once
// Notes:   Update goes out one cycle after the write it follows
`timescale 1ns/10ps
module ddsc_ctl
	import ddsc_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic [SW_ADDR_W-1:0]  sw_addr,
	input  wire logic [DATA_W-1:0]     sw_wdata,
	input  wire logic                  sw_wr,
	input  wire logic                  sw_rd,
	output logic [DATA_W-1:0]          sw_rdata,
	ddsc_link_if.ctl                   lnk
);

	logic                 dev_sel;
	logic                 ref_bad;
	logic                 fwd_wr;
	logic                 auto_reg;
	logic                 upd_reg;
	logic                 err_reg;
	logic                 rd_dev_reg;
	logic [DATA_W-1:0]    own_rdata_reg;
	logic [REF_W-1:0]     ref_reg;
	logic [SYS_W-1:0]     sys_est;
	logic [CFG_MULT_W-1:0] wfact;
	logic [DATA_W-1:0]    wdata_fix;

	// ----------------------------------------------------------------
	// Write forwarding
	// ----------------------------------------------------------------
	assign dev_sel = (sw_addr[SW_ADDR_W-1:ADDR_W] == '0);
	assign ref_bad = (sw_addr[ADDR_W-1:0] == DEV_REF_FREQ)
		&& (sw_wdata > {{(DATA_W-REF_W){1'b0}}, REF_MAX_MHZ});
	assign fwd_wr  = sw_wr && dev_sel && !ref_bad;
	assign wfact   = sw_wdata[CFG_MULT_LSB +: CFG_MULT_W];
	assign sys_est = SYS_W'(ref_reg * wfact);

	// High gain forced when the multiplied clock would exceed the stable range
	always_comb begin
		wdata_fix = sw_wdata;
		if ((sw_addr[ADDR_W-1:0] == DEV_CLK_CFG) && (wfact >= MULT_MIN)
			&& (wfact <= MULT_MAX) && (sys_est > GAIN_HI_MHZ)) begin
			wdata_fix[CFG_GAIN_BIT] = 1'b1;
		end
	end

	assign lnk.wr     = fwd_wr;
	assign lnk.rd     = sw_rd && dev_sel;
	assign lnk.addr   = sw_addr[ADDR_W-1:0];
	assign lnk.wdata  = wdata_fix;
	assign lnk.update = upd_reg;

	// ----------------------------------------------------------------
	// Update strobe and mode
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			upd_reg <= 1'b0;
		end else begin
			upd_reg <= (fwd_wr && auto_reg) || (sw_wr && (sw_addr == CTL_UPDATE));
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			auto_reg <= 1'b1;
		end else if (sw_wr && (sw_addr == CTL_MODE)) begin
			auto_reg <= sw_wdata[0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ref_reg <= REF_RESET;
		end else if (fwd_wr && (sw_addr[ADDR_W-1:0] == DEV_REF_FREQ)) begin
			ref_reg <= sw_wdata[REF_W-1:0];
		end
	end

	// Sticky range error; a new refusal wins over a clear in the same cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			err_reg <= 1'b0;
		end else if (sw_wr && dev_sel && ref_bad) begin
			err_reg <= 1'b1;
		end else if (sw_wr && (sw_addr == CTL_STATUS) && sw_wdata[STAT_REF_ERR]) begin
			err_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_dev_reg    <= 1'b0;
			own_rdata_reg <= '0;
		end else begin
			rd_dev_reg <= sw_rd && dev_sel;
			if (sw_rd && (sw_addr == CTL_MODE)) begin
				own_rdata_reg <= {{(DATA_W-1){1'b0}}, auto_reg};
			end else if (sw_rd && (sw_addr == CTL_STATUS)) begin
				own_rdata_reg <= {{(DATA_W-2){1'b0}}, auto_reg, err_reg};
			end else begin
				own_rdata_reg <= '0;
			end
		end
	end

	assign sw_rdata = rd_dev_reg ? lnk.rdata : own_rdata_reg;

endmodule

// ---- logic/ddsc_dev.sv ----
// Purpose: Chip-level control of a two-channel synthesizer: buffered registers,
//          clock multiplier setup and accumulator clearing
// Assumes: Link inputs are synchronous to clk, which stands in for the system clock
// Notes:   Writes land in a buffer; only the update strobe changes behaviour
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps

// Notes on behaviour
// - Writes stay buffered until update strobe
// - Update copies whole buffer to active
// - Controller chooses per-write or grouped updates
// - Multiplier factor 4 to 20 scales reference
// - Multiplier disabled by default: reference bypasses
// - Controller keeps reference at most 500 MHz
// - Controller sets high gain on clock config writes that multiply above 255 MHz
// - Pump current selectable, default 75 uA
// - Auto-clear zeroes accumulator once, then resumes
// - Clear holds accumulator zero while set
// - Chip-level clears act on both channels
// - Current settings can be read back
module ddsc_dev
	import ddsc_pkg::*;
(
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	ddsc_link_if.dev                           lnk,
	output logic [NUM_CH-1:0][DATA_W-1:0]      phase_acc,
	output logic [NUM_CH-1:0][DATA_W-1:0]      sweep_acc,
	output logic [CFG_MULT_W-1:0]              mult_factor,
	output logic                               mult_bypass,
	output logic [CFG_PUMP_W-1:0]              pump_current_select,
	output logic                               oscillator_gain_select,
	output logic [SYS_W-1:0]                   sysclk_mhz
);

	// ----------------------------------------------------------------
	// Buffer and active registers
	// ----------------------------------------------------------------
	logic [CFG_W-1:0]               buf_cfg_reg;
	logic [CFG_W-1:0]               buf_cfg_next;
	logic [REF_W-1:0]               buf_ref_reg;
	logic [REF_W-1:0]               buf_ref_next;
	logic [ACC_W-1:0]               buf_acc_reg;
	logic [ACC_W-1:0]               buf_acc_next;
	logic [NUM_CH-1:0][DATA_W-1:0]  buf_ftw_reg;
	logic [NUM_CH-1:0][DATA_W-1:0]  buf_ftw_next;
	logic [NUM_CH-1:0][DATA_W-1:0]  buf_swp_reg;
	logic [NUM_CH-1:0][DATA_W-1:0]  buf_swp_next;
	logic [CFG_W-1:0]               act_cfg_reg;
	logic [REF_W-1:0]               act_ref_reg;
	logic [ACC_W-1:0]               act_acc_reg;
	logic [NUM_CH-1:0][DATA_W-1:0]  act_ftw_reg;
	logic [NUM_CH-1:0][DATA_W-1:0]  act_swp_reg;
	logic                           auto_phase_reg;
	logic                           auto_sweep_reg;
	logic [DATA_W-1:0]              rdata_reg;
	logic [SYS_W-1:0]               sysclk_reg;
	logic [CFG_MULT_W-1:0]          fact;
	logic                           fact_ok;

	// ----------------------------------------------------------------
	// Buffer write path
	// ----------------------------------------------------------------
	// A write in the same cycle as the update is taken into the commit
	always_comb begin
		buf_cfg_next = buf_cfg_reg;
		buf_ref_next = buf_ref_reg;
		buf_acc_next = buf_acc_reg;
		buf_ftw_next = buf_ftw_reg;
		buf_swp_next = buf_swp_reg;
		if (lnk.wr) begin
			if (lnk.addr == DEV_CLK_CFG) begin
				buf_cfg_next = lnk.wdata[CFG_W-1:0];
			end else if (lnk.addr == DEV_REF_FREQ) begin
				buf_ref_next = lnk.wdata[REF_W-1:0];
			end else if (lnk.addr == DEV_ACC_CTRL) begin
				buf_acc_next = lnk.wdata[ACC_W-1:0];
			end else if (lnk.addr == DEV_FTW0) begin
				buf_ftw_next[0] = lnk.wdata;
			end else if (lnk.addr == DEV_FTW1) begin
				buf_ftw_next[1] = lnk.wdata;
			end else if (lnk.addr == DEV_SWEEP0) begin
				buf_swp_next[0] = lnk.wdata;
			end else if (lnk.addr == DEV_SWEEP1) begin
				buf_swp_next[1] = lnk.wdata;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			buf_cfg_reg <= CFG_RESET;
			buf_ref_reg <= REF_RESET;
			buf_acc_reg <= ACC_RESET;
			buf_ftw_reg <= '0;
			buf_swp_reg <= '0;
		end else begin
			buf_cfg_reg <= buf_cfg_next;
			buf_ref_reg <= buf_ref_next;
			buf_acc_reg <= buf_acc_next;
			buf_ftw_reg <= buf_ftw_next;
			buf_swp_reg <= buf_swp_next;
		end
	end

	// ----------------------------------------------------------------
	// Commit on update
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			act_cfg_reg <= CFG_RESET;
			act_ref_reg <= REF_RESET;
			act_acc_reg <= ACC_RESET;
			act_ftw_reg <= '0;
			act_swp_reg <= '0;
		end else if (lnk.update) begin
			act_cfg_reg <= buf_cfg_next;
			act_ref_reg <= buf_ref_next;
			act_acc_reg <= buf_acc_next;
			act_ftw_reg <= buf_ftw_next;
			act_swp_reg <= buf_swp_next;
		end
	end

	// ----------------------------------------------------------------
	// Auto-clear, one cycle per update that carries the bit
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			auto_phase_reg <= 1'b0;
			auto_sweep_reg <= 1'b0;
		end else begin
			auto_phase_reg <= lnk.update && buf_acc_next[ACC_AUTO_PHASE];
			auto_sweep_reg <= lnk.update && buf_acc_next[ACC_AUTO_SWEEP];
		end
	end

	// ----------------------------------------------------------------
	// Accumulators
	// ----------------------------------------------------------------
	// One clear term feeds every channel so both start from zero together
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					phase_acc[ch] <= '0;
				end else if (act_acc_reg[ACC_CLR_PHASE]) begin
					phase_acc[ch] <= '0;
				end else if (auto_phase_reg) begin
					phase_acc[ch] <= '0;
				end else begin
					phase_acc[ch] <= phase_acc[ch] + act_ftw_reg[ch];
				end
			end

			always_ff @(posedge clk) begin
				if (!rst_n) begin
					sweep_acc[ch] <= '0;
				end else if (act_acc_reg[ACC_CLR_SWEEP]) begin
					sweep_acc[ch] <= '0;
				end else if (auto_sweep_reg) begin
					sweep_acc[ch] <= '0;
				end else begin
					sweep_acc[ch] <= sweep_acc[ch] + act_swp_reg[ch];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Clock multiplier setup
	// ----------------------------------------------------------------
	// Out-of-range factors fall back to bypass rather than an unlocked loop
	assign fact    = act_cfg_reg[CFG_MULT_LSB +: CFG_MULT_W];
	assign fact_ok = (fact >= MULT_MIN) && (fact <= MULT_MAX);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sysclk_reg <= {{(SYS_W-REF_W){1'b0}}, REF_RESET};
		end else if (fact_ok) begin
			sysclk_reg <= SYS_W'(act_ref_reg * fact);
		end else begin
			sysclk_reg <= {{(SYS_W-REF_W){1'b0}}, act_ref_reg};
		end
	end

	assign sysclk_mhz             = sysclk_reg;
	assign mult_factor            = fact;
	assign mult_bypass            = !fact_ok;
	assign pump_current_select    = act_cfg_reg[CFG_PUMP_LSB +: CFG_PUMP_W];
	assign oscillator_gain_select = act_cfg_reg[CFG_GAIN_BIT];

	// ----------------------------------------------------------------
	// Readback of active settings
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_reg <= '0;
		end else if (lnk.rd) begin
			if (lnk.addr == DEV_CLK_CFG) begin
				rdata_reg <= {{(DATA_W-CFG_W){1'b0}}, act_cfg_reg};
			end else if (lnk.addr == DEV_REF_FREQ) begin
				rdata_reg <= {{(DATA_W-REF_W){1'b0}}, act_ref_reg};
			end else if (lnk.addr == DEV_ACC_CTRL) begin
				rdata_reg <= {{(DATA_W-ACC_W){1'b0}}, act_acc_reg};
			end else if (lnk.addr == DEV_FTW0) begin
				rdata_reg <= act_ftw_reg[0];
			end else if (lnk.addr == DEV_FTW1) begin
				rdata_reg <= act_ftw_reg[1];
			end else if (lnk.addr == DEV_SWEEP0) begin
				rdata_reg <= act_swp_reg[0];
			end else if (lnk.addr == DEV_SWEEP1) begin
				rdata_reg <= act_swp_reg[1];
			end else if (lnk.addr == DEV_SYSCLK) begin
				rdata_reg <= {{(DATA_W-SYS_W){1'b0}}, sysclk_reg};
			end else begin
				rdata_reg <= '0;
			end
		end
	end

	assign lnk.rdata = rdata_reg;

endmodule

// ---- logic/ddsc_link_if.sv ----
// Purpose: Link between the external controller and the synthesizer control logic
// Assumes: Both ends on clk; all signals synchronous
// Notes:   rdata is valid in the cycle after rd
`timescale 1ns/10ps
interface ddsc_link_if (
	input wire logic clk
);
	import ddsc_pkg::*;

	logic              wr;
	logic              rd;
	logic              update;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;

	modport dev (
		input  clk,
		input  wr,
		input  rd,
		input  update,
		input  addr,
		input  wdata,
		output rdata
	);

	modport ctl (
		input  clk,
		output wr,
		output rd,
		output update,
		output addr,
		output wdata,
		input  rdata
	);
endinterface

// ---- logic/ddsc_pkg.sv ----
// Purpose: Shared constants for the synthesizer chip-level control link
// Assumes: One clock domain; link signals sampled on the rising edge
// Notes:   Device offsets are 4-bit word indices; controller offsets are 8-bit
package ddsc_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int NUM_CH = 2;
	localparam int SW_ADDR_W = 8;

	// ----------------------------------------------------------------
	// Device register offsets
	// ----------------------------------------------------------------
	localparam logic [3:0] DEV_CLK_CFG  = 4'h0;
	localparam logic [3:0] DEV_REF_FREQ = 4'h1;
	localparam logic [3:0] DEV_ACC_CTRL = 4'h2;
	localparam logic [3:0] DEV_FTW0     = 4'h3;
	localparam logic [3:0] DEV_FTW1     = 4'h4;
	localparam logic [3:0] DEV_SWEEP0   = 4'h5;
	localparam logic [3:0] DEV_SWEEP1   = 4'h6;
	localparam logic [3:0] DEV_SYSCLK   = 4'h7;

	// ----------------------------------------------------------------
	// Field layouts
	// ----------------------------------------------------------------
	localparam int CFG_MULT_LSB = 0;
	localparam int CFG_MULT_W   = 5;
	localparam int CFG_PUMP_LSB = 5;
	localparam int CFG_PUMP_W   = 2;
	localparam int CFG_GAIN_BIT = 7;
	localparam int CFG_W        = 8;
	localparam int REF_W        = 10;
	localparam int SYS_W        = 15;
	localparam int ACC_CLR_PHASE  = 0;
	localparam int ACC_CLR_SWEEP  = 1;
	localparam int ACC_AUTO_PHASE = 2;
	localparam int ACC_AUTO_SWEEP = 3;
	localparam int ACC_W          = 4;

	// ----------------------------------------------------------------
	// Values and limits
	// ----------------------------------------------------------------
	localparam logic [4:0] MULT_MIN = 5'h04;
	localparam logic [4:0] MULT_MAX = 5'h14;
	localparam logic [1:0] PUMP_75UA  = 2'h0;
	localparam logic [1:0] PUMP_100UA = 2'h1;
	localparam logic [1:0] PUMP_125UA = 2'h2;
	localparam logic [1:0] PUMP_150UA = 2'h3;
	localparam logic [9:0]  REF_MAX_MHZ    = 10'h1F4;
	localparam logic [14:0] GAIN_HI_MHZ    = 15'h00FF;
	localparam logic [7:0]  CFG_RESET      = 8'h00;
	localparam logic [9:0]  REF_RESET      = 10'h1F4;
	localparam logic [3:0]  ACC_RESET      = 4'h0;

	// ----------------------------------------------------------------
	// Controller register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] CTL_MODE   = 8'h10;
	localparam logic [7:0] CTL_UPDATE = 8'h11;
	localparam logic [7:0] CTL_STATUS = 8'h12;
	localparam int STAT_REF_ERR = 0;
	localparam int STAT_AUTO    = 1;

endpackage

// ---- tb/ddsc_assertions.sv ----
// Purpose: Link and software port checks for the synthesizer control pair
// Assumes: Single clock; signals watched straight off the link and the port
// Notes:   Instantiated beside the link interface, no bind
`timescale 1ns/10ps
module ddsc_assertions
	import ddsc_pkg::*;
(
	input wire logic                  clk,
	input wire logic                  rst_n,
	input wire logic                  wr,
	input wire logic                  rd,
	input wire logic                  update,
	input wire logic [ADDR_W-1:0]     addr,
	input wire logic [DATA_W-1:0]     rdata,
	input wire logic [SW_ADDR_W-1:0]  sw_addr,
	input wire logic [DATA_W-1:0]     sw_wdata,
	input wire logic                  sw_wr,
	input wire logic                  sw_rd,
	input wire logic [DATA_W-1:0]     sw_rdata,
	input wire logic [CFG_MULT_W-1:0] mult_factor,
	input wire logic                  mult_bypass,
	input wire logic [CFG_PUMP_W-1:0] pump_current_select,
	input wire logic                  oscillator_gain_select,
	input wire logic [SYS_W-1:0]      sysclk_mhz
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	wire logic dev_sel = (sw_addr[7:4] == 4'h0);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	AST_RDATA_HOLD: assert property (!$past(rd) |-> $stable(rdata))
		else $error("link read data moved without a read");
	AST_ACTIVE_HOLD: assert property (!$past(update) |-> $stable(mult_factor)
		&& $stable(pump_current_select) && $stable(oscillator_gain_select))
		else $error("active setting changed without an update");
	AST_BYPASS_RANGE: assert property (mult_bypass ==
		(mult_factor < MULT_MIN || mult_factor > MULT_MAX))
		else $error("bypass does not follow factor range");
	AST_SYSCLK_TIMING: assert property ($changed(sysclk_mhz) |-> $past(update, 2))
		else $error("system clock figure changed off the commit timing");
	AST_MANUAL_UPDATE: assert property (sw_wr && sw_addr == CTL_UPDATE |=> update)
		else $error("manual update did not reach the link");
	AST_REF_REFUSE: assert property (sw_wr && sw_addr == 8'h01
		&& sw_wdata > 32'h0000_01F4 |-> !wr ##1 !update)
		else $error("reference above limit was forwarded");
	AST_WR_FORWARD: assert property (sw_wr && dev_sel && sw_addr[3:0] != DEV_REF_FREQ
		|-> wr && addr == sw_addr[3:0])
		else $error("device write not forwarded");
	AST_RD_PATH: assert property ($past(sw_rd) && $past(dev_sel) |-> sw_rdata == rdata)
		else $error("software read data differs from link read data");
	AST_NO_STRAY: assert property (!sw_wr && !sw_rd |-> !wr && !rd)
		else $error("link access without a software access");

	COV_MANUAL: cover property (sw_wr && sw_addr == CTL_UPDATE ##1 update);
	COV_REFUSE: cover property (sw_wr && sw_addr == 8'h01 && !wr);
	COV_SYSCLK: cover property ($changed(sysclk_mhz));
endmodule

// ---- tb/testbench.sv ----
// Purpose: Drives the software port of the controller end and checks both ends
// Assumes: 250 MHz clock, synchronous active low reset
// Notes:   Expectations worked out from the package constants
`timescale 1ns/10ps
module testbench;
	import ddsc_pkg::*;
	logic                             clk;
	logic                             rst_n;
	logic [SW_ADDR_W-1:0]             sw_addr;
	logic [DATA_W-1:0]                sw_wdata;
	logic                             sw_wr;
	logic                             sw_rd;
	logic [DATA_W-1:0]                sw_rdata;
	logic [NUM_CH-1:0][DATA_W-1:0]    phase_acc;
	logic [NUM_CH-1:0][DATA_W-1:0]    sweep_acc;
	logic [CFG_MULT_W-1:0]            mult_factor;
	logic                             mult_bypass;
	logic [CFG_PUMP_W-1:0]            pump_current_select;
	logic                             oscillator_gain_select;
	logic [SYS_W-1:0]                 sysclk_mhz;
	logic [4:0]                       facs [4] = '{5'h03, 5'h04, 5'h14, 5'h15};
	logic                             inr;
	int                               errors;
	int                               checks_done;

	ddsc_link_if u_ddsc_link_if (.clk(clk));
	ddsc_ctl u_ddsc_ctl (.clk(clk), .rst_n(rst_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
		.sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .lnk(u_ddsc_link_if));
	ddsc_dev u_ddsc_dev (.clk(clk), .rst_n(rst_n), .lnk(u_ddsc_link_if), .phase_acc(phase_acc),
		.sweep_acc(sweep_acc), .mult_factor(mult_factor), .mult_bypass(mult_bypass),
		.pump_current_select(pump_current_select),
		.oscillator_gain_select(oscillator_gain_select), .sysclk_mhz(sysclk_mhz));
	ddsc_assertions u_ddsc_assertions (.clk(clk), .rst_n(rst_n), .wr(u_ddsc_link_if.wr),
		.rd(u_ddsc_link_if.rd), .update(u_ddsc_link_if.update), .addr(u_ddsc_link_if.addr),
		.rdata(u_ddsc_link_if.rdata), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
		.sw_rd(sw_rd), .sw_rdata(sw_rdata), .mult_factor(mult_factor),
		.mult_bypass(mult_bypass), .pump_current_select(pump_current_select),
		.oscillator_gain_select(oscillator_gain_select), .sysclk_mhz(sysclk_mhz));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One idle cycle between accesses keeps each strobe a clean single pulse
	task automatic sw_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge clk);
		sw_wr <= 1'b0;
	endtask
	task automatic read_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge clk);
		sw_rd <= 1'b0;
		#1;
		chk(sw_rdata, exp);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic acc_chk(input logic [31:0] p0, p1, s0, s1);
		chk(phase_acc[0], p0);
		chk(phase_acc[1], p1);
		chk(sweep_acc[0], s0);
		chk(sweep_acc[1], s1);
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Clock, watchdog and sequence
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Whole sequence needs well under 1000 cycles
	initial begin
		#40000;
		errors++;
		summarize();
	end
	initial begin
		errors = 0;
		checks_done = 0;
		rst_n = 1'b0;
		sw_addr = 8'h00;
		sw_wdata = 32'h0;
		sw_wr = 1'b0;
		sw_rd = 1'b0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		read_chk(8'h00, 32'h0);
		read_chk(8'h01, 32'h1F4);
		read_chk(CTL_STATUS, 32'h2);
		read_chk(8'h08, 32'h0);
		read_chk(8'h20, 32'h0);
		chk(mult_bypass, 32'h1);
		chk(pump_current_select, PUMP_75UA);
		chk(sysclk_mhz, 32'h1F4);
		$display("test reset done");
		sw_write(CTL_MODE, 32'h0);
		read_chk(CTL_MODE, 32'h0);
		sw_write(8'h00, 32'h44);
		sw_write(8'h03, 32'h100);
		settle(3);
		chk(mult_factor, 32'h0);
		read_chk(8'h00, 32'h0);
		sw_write(CTL_UPDATE, 32'h0);
		settle(2);
		chk(mult_factor, 32'h4);
		chk(pump_current_select, PUMP_125UA);
		chk(oscillator_gain_select, 32'h1);
		chk(sysclk_mhz, 32'h7D0);
		read_chk(8'h00, 32'hC4);
		read_chk(8'h03, 32'h100);
		sw_write(CTL_MODE, 32'h1);
		read_chk(CTL_MODE, 32'h1);
		$display("test manual update done");
		sw_write(8'h01, 32'h19);
		for (int i = 0; i < 4; i++) begin
			sw_write(8'h00, {27'h0, facs[i]});
			settle(2);
			inr = facs[i] >= MULT_MIN && facs[i] <= MULT_MAX;
			chk(mult_bypass, !inr);
			chk(sysclk_mhz, inr ? 32'h19 * facs[i] : 32'h19);
			if (inr)
				chk(oscillator_gain_select, 32'h19 * facs[i] > 32'hFF);
		end
		$display("test multiplier done");
		sw_write(8'h01, 32'h1F5);
		settle(2);
		read_chk(8'h01, 32'h19);
		read_chk(CTL_STATUS, 32'h3);
		sw_write(CTL_STATUS, 32'h1);
		read_chk(CTL_STATUS, 32'h2);
		sw_write(8'h01, 32'h1F4);
		settle(2);
		read_chk(8'h01, 32'h1F4);
		$display("test reference limit done");
		sw_write(8'h03, 32'h5);
		sw_write(8'h04, 32'h7);
		sw_write(8'h05, 32'h3);
		sw_write(8'h06, 32'h3);
		sw_write(8'h02, 32'h3);
		settle(2);
		for (int i = 0; i < 4; i++) begin
			acc_chk(32'h0, 32'h0, 32'h0, 32'h0);
			settle(1);
		end
		sw_write(8'h02, 32'h0);
		settle(2);
		acc_chk(32'h5, 32'h7, 32'h3, 32'h3);
		settle(1);
		acc_chk(32'hA, 32'hE, 32'h6, 32'h6);
		sw_write(8'h02, 32'hC);
		settle(2);
		acc_chk(32'h0, 32'h0, 32'h0, 32'h0);
		settle(1);
		acc_chk(32'h5, 32'h7, 32'h3, 32'h3);
		read_chk(8'h02, 32'hC);
		$display("test accumulators done");
		// Channel 1 and sweep words, and the read-only system clock word
		read_chk(8'h04, 32'h7);
		read_chk(8'h05, 32'h3);
		read_chk(8'h06, 32'h3);
		sw_write(8'h07, 32'h1234);
		settle(2);
		read_chk(8'h07, 32'h1F4);
		$display("test readback done");
		summarize();
	end
endmodule
